// ---- thermal_overload_replica_test.sv ----
// self-checking bench for the thermal overload replica
`timescale 1ns/1ps
`include "tor_defines.vh"
`define tor_chk(g, e) begin samples_checked++; if ((g) !== (e)) begin \
   fails++; $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module thermal_overload_replica_test;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] address = 8'h00;
   logic read = 1'h0;
   logic write = 1'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] q;
   int fails = 0;
   int samples_checked = 0;
   wire [31:0] readdata;
   wire [15:0] cur_a, cur_b, cur_c;
   wire [2:0] assigned_side;
   wire waitrequest, block_in, start_detect_in, emer_start_in, irq;
   wire thermal_warn, trip_alarm, trip_relay, current_warn, standstill;
   tor_front_model front (.clk, .cur_a, .cur_b, .cur_c, .block_in,
      .start_detect_in, .emer_start_in);
   tor_replica #(.UPD_CYCLES(8)) uut (.clk, .rst, .ce(1'h1), .address, .read,
      .write, .writedata, .readdata, .waitrequest, .cur_a, .cur_b, .cur_c,
      .block_in, .start_detect_in, .emer_start_in, .assigned_side,
      .thermal_warn, .trip_alarm, .trip_relay, .current_warn, .standstill,
      .irq);
   // 8 ns clock
   initial
   begin
      forever #4 clk = ~clk;
   end
   // one register access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      #1;
      while (waitrequest !== 1'h0 && n < 100)
      begin
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk);
      q = readdata;
      write <= 1'h0;
      read <= 1'h0;
      #1;
      if (n == 100) fails++;
   endtask
   // wait whole replica update intervals
   task automatic ticks(input int n);
      repeat (n * 8) @(posedge clk);
      #1;
   endtask
   // reset values and an unmapped read
   task automatic t_regs;
      logic [7:0] a [10] = '{`TOR_REG_CTRL, `TOR_REG_SCALE, `TOR_REG_HEAT_ALPHA,
         `TOR_REG_COOL_MUL, `TOR_REG_WARN_TH, `TOR_REG_TRIP_TH,
         `TOR_REG_CUR_WARN, `TOR_REG_MIN_CUR, `TOR_REG_RUNON, 8'h3C};
      logic [31:0] e [10] = '{`TOR_RST_CTRL, `TOR_RST_SCALE,
         `TOR_RST_HEAT_ALPHA, `TOR_RST_COOL_MUL, `TOR_RST_WARN_TH,
         `TOR_RST_TRIP_TH, `TOR_RST_CUR_WARN, `TOR_RST_MIN_CUR,
         `TOR_RST_RUNON, 32'h0};
      for (int i = 0; i < 10; i++)
      begin
         bus(1'h0, a[i], 32'h0);
         `tor_chk(q, e[i])
      end
   endtask
   // overload on one phase in each mode but off, then block
   task automatic t_modes;
      logic [1:0] m [3] = '{`TOR_MODE_ON, `TOR_MODE_ALARM, `TOR_MODE_BLKREL};
      for (int i = 0; i < 3; i++)
      begin
         bus(1'h1, `TOR_REG_CTRL, {30'h0, m[i]});
         front.set_cur(16'h0000, 16'h2000, 16'h0000);
         ticks(2);
         `tor_chk(thermal_warn, 1'h1)
         `tor_chk(trip_alarm, 1'h1)
         `tor_chk(trip_relay, m[i] == `TOR_MODE_ON)
         bus(1'h0, `TOR_REG_THETA_MAX, 32'h0);
         `tor_chk(q >= {8'h00, `TOR_RST_TRIP_TH}, 1'h1)
         front.set_pins(1'h1, 1'h0, 1'h0);
         ticks(1);
         `tor_chk({thermal_warn, trip_alarm, trip_relay}, 3'h0)
         bus(1'h0, `TOR_REG_THETA_MAX, 32'h0);
         `tor_chk(q, 32'h0)
         front.set_pins(1'h0, 1'h0, 1'h0);
         front.set_cur(16'h0000, 16'h0000, 16'h0000);
      end
   endtask
   // trip event raised, masked, unmasked and cleared
   task automatic t_irq;
      bus(1'h1, `TOR_REG_CTRL, 32'h1);
      front.set_cur(16'h2000, 16'h0000, 16'h0000);
      ticks(2);
      `tor_chk(irq, 1'h0)
      bus(1'h1, `TOR_REG_IRQ_MASK, 32'h2);
      `tor_chk(irq, 1'h1)
      bus(1'h1, `TOR_REG_IRQ_STAT, 32'h2);
      `tor_chk(irq, 1'h0)
      bus(1'h0, `TOR_REG_IRQ_STAT, 32'h0);
      `tor_chk(q[1], 1'h0)
   endtask
   // emergency start and its run-on time
   task automatic t_emer;
      bus(1'h1, `TOR_REG_RUNON, 32'h3);
      front.set_pins(1'h0, 1'h0, 1'h1);
      ticks(3);
      `tor_chk(trip_alarm, 1'h1)
      `tor_chk(trip_relay, 1'h0)
      front.set_pins(1'h0, 1'h0, 1'h0);
      ticks(1);
      `tor_chk(trip_relay, 1'h0)
      ticks(5);
      `tor_chk(trip_relay, 1'h1)
      front.set_pins(1'h1, 1'h0, 1'h0);
      front.set_cur(16'h0000, 16'h0000, 16'h0000);
      ticks(1);
   endtask
   // standstill and current warning boundaries
   task automatic t_stand;
      logic [31:0] t1;
      front.set_pins(1'h0, 1'h0, 1'h0);
      ticks(3);
      `tor_chk(standstill, 1'h1)
      `tor_chk(current_warn, 1'h0)
      front.set_cur(16'h1000, 16'h0000, 16'h0000);
      ticks(2);
      `tor_chk(current_warn, 1'h0)
      `tor_chk(standstill, 1'h0)
      front.set_cur(16'h0200, 16'h1001, 16'h0200);
      ticks(2);
      `tor_chk(current_warn, 1'h1)
      // at standstill the replica must cool slower than it heats
      front.set_cur(16'h0000, 16'h0000, 16'h0000);
      ticks(1);
      bus(1'h0, `TOR_REG_THETA_MAX, 32'h0);
      t1 = q;
      ticks(1);
      bus(1'h0, `TOR_REG_THETA_MAX, 32'h0);
      `tor_chk(q < t1 && 2 * q > t1, 1'h1)
   endtask
   // start detection holds the cleared replica
   task automatic t_start;
      front.set_pins(1'h1, 1'h0, 1'h0);
      ticks(1);
      front.set_pins(1'h0, 1'h1, 1'h0);
      ticks(1);
      front.set_cur(16'h2000, 16'h2000, 16'h2000);
      ticks(3);
      bus(1'h0, `TOR_REG_THETA_MAX, 32'h0);
      `tor_chk(q, 32'h0)
      `tor_chk(thermal_warn, 1'h0)
      front.set_pins(1'h0, 1'h0, 1'h0);
      front.set_cur(16'h0000, 16'h0000, 16'h0000);
   endtask
   // side assignment, valid and out of range
   task automatic t_side;
      bus(1'h1, `TOR_REG_CTRL, 32'h41);
      `tor_chk(assigned_side, 3'h4)
      bus(1'h0, `TOR_REG_STATUS, 32'h0);
      `tor_chk(q[`TOR_EV_NAVAIL], 1'h0)
      bus(1'h1, `TOR_REG_CTRL, 32'h61);
      bus(1'h0, `TOR_REG_STATUS, 32'h0);
      `tor_chk(q[`TOR_EV_NAVAIL], 1'h1)
   endtask
   // counts and verdict
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // reset, then every scenario
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      t_regs;
      bus(1'h1, `TOR_REG_HEAT_ALPHA, 32'h8000);
      t_modes;
      t_irq;
      t_emer;
      t_stand;
      t_start;
      t_side;
      final_report;
   end
   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      final_report;
   end
endmodule // thermal_overload_replica_test

// ---- tor_defines.vh ----
// constants for the thermal overload replica block
`ifndef TOR_DEFINES_VH
`define TOR_DEFINES_VH

// register byte offsets
`define TOR_REG_CTRL 8'h00
`define TOR_REG_SCALE 8'h04
`define TOR_REG_HEAT_ALPHA 8'h08
`define TOR_REG_COOL_MUL 8'h0C
`define TOR_REG_WARN_TH 8'h10
`define TOR_REG_TRIP_TH 8'h14
`define TOR_REG_CUR_WARN 8'h18
`define TOR_REG_MIN_CUR 8'h1C
`define TOR_REG_RUNON 8'h20
`define TOR_REG_STATUS 8'h24
`define TOR_REG_IRQ_STAT 8'h28
`define TOR_REG_IRQ_MASK 8'h2C
`define TOR_REG_THETA_MAX 8'h30

// control field positions
`define TOR_CTRL_MODE_LSB 0
`define TOR_CTRL_MODE_MSB 1
`define TOR_CTRL_SIDE_LSB 4
`define TOR_CTRL_SIDE_MSB 6

// operating modes
`define TOR_MODE_OFF 2'h0
`define TOR_MODE_ON 2'h1
`define TOR_MODE_ALARM 2'h2
`define TOR_MODE_BLKREL 2'h3

// interrupt and status bit positions
`define TOR_EV_WARN 0
`define TOR_EV_TRIP 1
`define TOR_EV_CWARN 2
`define TOR_EV_NAVAIL 3
`define TOR_ST_STANDSTILL 4
`define TOR_ST_SUPPRESS 5
`define TOR_ST_RELAY 6

// reset values
`define TOR_RST_CTRL 7'h00
`define TOR_RST_SCALE 16'h1000
`define TOR_RST_HEAT_ALPHA 16'h0001
`define TOR_RST_COOL_MUL 16'h8000
`define TOR_RST_WARN_TH 24'h00E666
`define TOR_RST_TRIP_TH 24'h010000
`define TOR_RST_CUR_WARN 16'h1000
`define TOR_RST_MIN_CUR 16'h0100
`define TOR_RST_RUNON 16'h0064

// timing
`define TOR_CLK_PERIOD_NS 8
`define TOR_UPD_INTERVAL_US 1000

`endif

// ---- tor_front_model.sv ----
// phase current measurement and binary input pins
`timescale 1ns/1ps
module tor_front_model (
   // clock
   input wire clk,
   // phase currents
   output reg [15:0] cur_a = 16'h0000,
   output reg [15:0] cur_b = 16'h0000,
   output reg [15:0] cur_c = 16'h0000,
   // binary inputs
   output reg block_in = 1'h0,
   output reg start_detect_in = 1'h0,
   output reg emer_start_in = 1'h0
);
   // new phase currents right after an edge
   task automatic set_cur(input logic [15:0] a, b, c);
      @(posedge clk);
      cur_a <= a;
      cur_b <= b;
      cur_c <= c;
   endtask
   // new pin levels right after an edge
   task automatic set_pins(input logic blk, st, em);
      @(posedge clk);
      block_in <= blk;
      start_detect_in <= st;
      emer_start_in <= em;
   endtask
endmodule // tor_front_model

// ---- tor_replica.v ----
// thermal overload replica with register slave and interrupt
`timescale 1ns/1ps
`include "tor_defines.vh"

module tor_replica #(
   parameter UPD_CYCLES = `TOR_UPD_INTERVAL_US * 1000 / `TOR_CLK_PERIOD_NS,
   parameter NUM_SIDES = 5,
   parameter BUSBAR_1PH = 0
)(
   // clock, reset, enable
   input wire clk,
   input wire rst,
   input wire ce,
   // avalon-mm slave
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output wire waitrequest,
   // phase rms currents of the assigned side, same clock
   input wire [15:0] cur_a,
   input wire [15:0] cur_b,
   input wire [15:0] cur_c,
   // binary inputs from pins
   input wire block_in,
   input wire start_detect_in,
   input wire emer_start_in,
   // side selection towards the measuring front end
   output wire [2:0] assigned_side,
   // indications and relay
   output reg thermal_warn,
   output reg trip_alarm,
   output reg trip_relay,
   output reg current_warn,
   output reg standstill,
   output wire irq
);

   // configuration registers
   reg [6:0] ctrl;
   reg [15:0] scale;
   reg [15:0] heat_alpha;
   reg [15:0] cool_mul;
   reg [23:0] warn_th;
   reg [23:0] trip_th;
   reg [15:0] current_warning_level;
   reg [15:0] side_min_current_threshold;
   reg [15:0] runon;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg ack;

   // synchronisers for pin inputs
   reg [2:0] sync1;
   reg [2:0] sync2;
   reg emer_d;

   // update timer and run-on timer
   reg [31:0] tick_cnt;
   reg [15:0] runon_cnt;
   wire tick;

   // phase state
   wire [23:0] theta [0:2];
   wire [15:0] cur [0:2];
   wire [23:0] theta_upd [0:2];
   wire [2:0] over_cw;
   wire [2:0] under_min;

   wire [1:0] mode;
   wire not_avail;
   wire active;
   wire clear_rep;
   wire suppress;
   wire [23:0] theta_max;
   wire [16:0] cool_alpha;
   wire [16:0] alpha_sel;
   wire [31:0] cool_prod;
   wire warn_now;
   wire trip_now;
   wire [3:0] ev;
   wire wr_acc;
   wire rd_acc;
   wire start_detect_sync;

   assign mode = ctrl[`TOR_CTRL_MODE_MSB:`TOR_CTRL_MODE_LSB];
   assign assigned_side = ctrl[`TOR_CTRL_SIDE_MSB:`TOR_CTRL_SIDE_LSB];

   // refuse unassigned sides and single-phase busbar use
   assign not_avail = (BUSBAR_1PH != 0) ||
      ({29'h0, assigned_side} >= NUM_SIDES);
   assign active = (mode != `TOR_MODE_OFF) && !not_avail;
   assign clear_rep = !active || sync2[0];
   assign suppress = sync2[2] || (runon_cnt != 16'h0000);

   // fixed update interval
   assign tick = (tick_cnt == 32'h00000000);

   // cooling slope is the heating slope times cool_mul over 65536
   assign cool_prod = heat_alpha * cool_mul;
   assign cool_alpha = {1'b0, cool_prod[31:16]};
   assign alpha_sel = standstill ? cool_alpha : {1'b0, heat_alpha};

   assign cur[0] = cur_a;
   assign cur[1] = cur_b;
   assign cur[2] = cur_c;

   // one replica datapath per phase
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : phase
         wire [31:0] r_prod;
         wire [15:0] ratio;
         wire [31:0] r_sq;
         wire signed [24:0] diff;
         wire signed [41:0] step_prod;
         wire signed [25:0] step;
         wire signed [26:0] sum;
         reg [23:0] th;
         // current over k times rated current, saturating
         assign r_prod = cur[g] * scale;
         assign ratio = (r_prod[31:28] != 4'h0) ? 16'hFFFF : r_prod[27:12];
         assign r_sq = ratio * ratio;
         // discrete first-order lag toward the squared ratio
         assign diff = $signed({1'b0, r_sq[31:8]}) -
            $signed({1'b0, theta[g]});
         assign step_prod = diff * $signed(alpha_sel);
         assign step = step_prod[41:16];
         assign sum = $signed({3'b000, theta[g]}) + $signed({step[25], step});
         // hold rises during start, clamp to the register range
         assign theta_upd[g] = (start_detect_sync && !step[25]) ? theta[g] :
            sum[26] ? 24'h000000 :
            (sum[25:24] != 2'b00) ? 24'hFFFFFF : sum[23:0];
         assign over_cw[g] = cur[g] > current_warning_level;
         assign under_min[g] = cur[g] < side_min_current_threshold;
         // replica register, one driver per phase
         assign theta[g] = th;
         always @(posedge clk or posedge rst)
         begin
            if (rst)
               th <= 24'h000000;
            else if (ce)
            begin
               if (clear_rep)
                  th <= 24'h000000;
               else if (tick)
                  th <= theta_upd[g];
            end
         end
      end
   endgenerate

   assign start_detect_sync = sync2[1];

   // largest of the three rises
   assign theta_max = (theta[0] >= theta[1]) ?
      ((theta[0] >= theta[2]) ? theta[0] : theta[2]) :
      ((theta[1] >= theta[2]) ? theta[1] : theta[2]);
   assign warn_now = theta_max >= warn_th;
   assign trip_now = theta_max >= trip_th;

   // two-flop synchronisers: block, start detect, emergency start
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         emer_d <= 1'b0;
      end
      else if (ce)
      begin
         sync1 <= {emer_start_in, start_detect_in, block_in};
         sync2 <= sync1;
         emer_d <= sync2[2];
      end
   end

   // update interval counter
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         tick_cnt <= 32'h00000000;
      else if (ce)
      begin
         if (tick)
            tick_cnt <= UPD_CYCLES - 1;
         else
            tick_cnt <= tick_cnt - 32'h00000001;
      end
   end

   // emergency run-on timer, counted in update intervals
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         runon_cnt <= 16'h0000;
      else if (ce)
      begin
         if (sync2[2])
            runon_cnt <= 16'h0000;
         else if (emer_d)
            runon_cnt <= runon;
         else if (tick && runon_cnt != 16'h0000)
            runon_cnt <= runon_cnt - 16'h0001;
      end
   end

   // indications and relay; only the relay sees emergency start
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         thermal_warn <= 1'b0;
         trip_alarm <= 1'b0;
         trip_relay <= 1'b0;
         current_warn <= 1'b0;
         standstill <= 1'b0;
      end
      else if (ce)
      begin
         thermal_warn <= !clear_rep && warn_now;
         trip_alarm <= !clear_rep && trip_now;
         trip_relay <= !clear_rep && trip_now && (mode == `TOR_MODE_ON) &&
            !suppress;
         current_warn <= !clear_rep && (over_cw != 3'b000);
         standstill <= active && (under_min == 3'b111);
      end
   end

   // rising edges of warn, trip and current warning, and the not-available level, are interrupt events
   assign ev = {not_avail & (mode != `TOR_MODE_OFF),
      !clear_rep && (over_cw != 3'b000) && !current_warn,
      !clear_rep && trip_now && !trip_alarm,
      !clear_rep && warn_now && !thermal_warn};
   assign irq = (irq_stat & irq_mask) != 4'h0;

   // bus handshake: one wait cycle, then the access completes
   assign waitrequest = (read || write) && !ack;
   assign wr_acc = write && ack;
   assign rd_acc = read && !ack; // load ahead so data stand at completion

   always @(posedge clk or posedge rst)
   begin
      if (rst)
         ack <= 1'b0;
      else if (ce)
         ack <= (read || write) && !ack;
   end

   // register writes
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl <= `TOR_RST_CTRL;
         scale <= `TOR_RST_SCALE;
         heat_alpha <= `TOR_RST_HEAT_ALPHA;
         cool_mul <= `TOR_RST_COOL_MUL;
         warn_th <= `TOR_RST_WARN_TH;
         trip_th <= `TOR_RST_TRIP_TH;
         current_warning_level <= `TOR_RST_CUR_WARN;
         side_min_current_threshold <= `TOR_RST_MIN_CUR;
         runon <= `TOR_RST_RUNON;
         irq_mask <= 4'h0;
      end
      else if (ce && wr_acc)
      begin
         if (address == `TOR_REG_CTRL)
            ctrl <= writedata[6:0];
         else if (address == `TOR_REG_SCALE)
            scale <= writedata[15:0];
         else if (address == `TOR_REG_HEAT_ALPHA)
            heat_alpha <= writedata[15:0];
         else if (address == `TOR_REG_COOL_MUL)
            cool_mul <= writedata[15:0];
         else if (address == `TOR_REG_WARN_TH)
            warn_th <= writedata[23:0];
         else if (address == `TOR_REG_TRIP_TH)
            trip_th <= writedata[23:0];
         else if (address == `TOR_REG_CUR_WARN)
            current_warning_level <= writedata[15:0];
         else if (address == `TOR_REG_MIN_CUR)
            side_min_current_threshold <= writedata[15:0];
         else if (address == `TOR_REG_RUNON)
            runon <= writedata[15:0];
         else if (address == `TOR_REG_IRQ_MASK)
            irq_mask <= writedata[3:0];
      end
   end

   // sticky events, write one to clear, a new event wins
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_stat <= 4'h0;
      else if (ce)
      begin
         if (wr_acc && address == `TOR_REG_IRQ_STAT)
            irq_stat <= (irq_stat & ~writedata[3:0]) | ev;
         else
            irq_stat <= irq_stat | ev;
      end
   end

   // read data, loaded at the first edge, standing at the completing one
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         readdata <= 32'h00000000;
      else if (ce && rd_acc)
      begin
         if (address == `TOR_REG_CTRL)
            readdata <= {25'h0, ctrl};
         else if (address == `TOR_REG_SCALE)
            readdata <= {16'h0, scale};
         else if (address == `TOR_REG_HEAT_ALPHA)
            readdata <= {16'h0, heat_alpha};
         else if (address == `TOR_REG_COOL_MUL)
            readdata <= {16'h0, cool_mul};
         else if (address == `TOR_REG_WARN_TH)
            readdata <= {8'h0, warn_th};
         else if (address == `TOR_REG_TRIP_TH)
            readdata <= {8'h0, trip_th};
         else if (address == `TOR_REG_CUR_WARN)
            readdata <= {16'h0, current_warning_level};
         else if (address == `TOR_REG_MIN_CUR)
            readdata <= {16'h0, side_min_current_threshold};
         else if (address == `TOR_REG_RUNON)
            readdata <= {16'h0, runon};
         else if (address == `TOR_REG_STATUS)
            readdata <= {25'h0, trip_relay, suppress, standstill, not_avail,
               current_warn, trip_alarm, thermal_warn};
         else if (address == `TOR_REG_IRQ_STAT)
            readdata <= {28'h0, irq_stat};
         else if (address == `TOR_REG_IRQ_MASK)
            readdata <= {28'h0, irq_mask};
         else if (address == `TOR_REG_THETA_MAX)
            readdata <= {8'h0, theta_max};
         else
            readdata <= 32'h00000000; // unmapped reads zero
      end
   end

endmodule // tor_replica

// ---- tor_replica_asserts.sv ----
// port assertions for the thermal overload replica
`timescale 1ns/1ps
module tor_replica_asserts (
   // clock and reset
   input wire clk,
   input wire rst,
   // register bus
   input wire [7:0] address,
   input wire read,
   input wire write,
   input wire waitrequest,
   // currents and pins
   input wire [15:0] cur_a,
   input wire [15:0] cur_b,
   input wire [15:0] cur_c,
   input wire block_in,
   input wire start_detect_in,
   input wire emer_start_in,
   // indications
   input wire [2:0] assigned_side,
   input wire thermal_warn,
   input wire trip_alarm,
   input wire trip_relay,
   input wire current_warn,
   input wire irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   reg [4:0] quiet;
   wire ctrl_wr = write && !waitrequest && address == 8'h00;
   // busy in the first cycle, ready in the second
   sequence s_req_ack;
      waitrequest ##1 !waitrequest;
   endsequence
   // cycles with every phase current at zero
   always @(posedge clk or posedge rst)
      if (rst)
         quiet <= 5'h00;
      else if (cur_a != 16'h0000 || cur_b != 16'h0000 || cur_c != 16'h0000)
         quiet <= 5'h00;
      else if (quiet != 5'h1F)
         quiet <= quiet + 5'h01;
   a_wait_first: assert property ($rose(read || write) |-> s_req_ack)
      else $error("access not answered in two cycles");
   a_relay_alarm: assert property (trip_relay |-> trip_alarm)
      else $error("relay without trip indication");
   a_trip_warn: assert property (trip_alarm |-> thermal_warn)
      else $error("trip without warning");
   a_emer_hold: assert property (emer_start_in [*5] |-> !trip_relay)
      else $error("relay during emergency start");
   a_block_clear: assert property (block_in [*5] |->
      !thermal_warn && !trip_alarm && !trip_relay)
      else $error("indication while blocked");
   a_start_freeze: assert property (start_detect_in [*5] |->
      !$rose(thermal_warn) && !$rose(trip_alarm))
      else $error("rise during start detection");
   a_zero_nowarn: assert property (quiet >= 5'h14 |-> !current_warn)
      else $error("current warning with no current");
   a_side_write: assert property ($changed(assigned_side) |->
      $past(ctrl_wr))
      else $error("side changed without control write");
   a_reset_quiet: assert property (disable iff (1'h0)
      rst |=> !trip_relay && !thermal_warn && !trip_alarm && !irq)
      else $error("output active in reset");
endmodule // tor_replica_asserts

bind tor_replica tor_replica_asserts chk (.clk, .rst, .address, .read,
   .write, .waitrequest, .cur_a, .cur_b, .cur_c, .block_in, .start_detect_in,
   .emer_start_in, .assigned_side, .thermal_warn, .trip_alarm, .trip_relay,
   .current_warn, .irq);
